// ---- design/fsp_pkg.sv ----
package fsp_pkg;

   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_OPTION     = 16'h1821;
   localparam logic [15:0] IDX_CONFIG     = 16'h1822;
   localparam logic [15:0] IDX_PROTECT    = 16'h1824;
   localparam logic [15:0] IDX_STATUS     = 16'h1825;
   localparam logic [15:0] ADDR_OPTION    = 16'(IDX_OPTION * 4);
   localparam logic [15:0] ADDR_CONFIG    = 16'(IDX_CONFIG * 4);
   localparam logic [15:0] ADDR_PROTECT   = 16'(IDX_PROTECT * 4);
   localparam logic [15:0] ADDR_STATUS    = 16'(IDX_STATUS * 4);

   // option shadow fields
   localparam int          OPT_BACKDOOR_KEY_ENABLE_BIT  = 7;
   localparam int          OPT_NORED_BIT  = 6;
   localparam logic [1:0]  SEC_UNSECURED  = 2'h2;
   localparam logic [1:0]  SEC_RESET      = 2'h0;

   // configuration and status fields
   localparam int          CFG_KEY_WRITE_ACCESS_BIT = 5;
   localparam logic [2:0]  CFG_RESET      = 3'h0;
   localparam int          STAT_VIOL_BIT  = 5;

   // protection shadow fields
   localparam int          PROT_DIS_BIT   = 0;
   localparam logic [8:0]  BOUNDARY_FILL  = 9'h1ff;
   localparam logic [7:0]  NV_RESET       = 8'h00;

   // backdoor key window
   localparam logic [15:0] KEY_BASE       = 16'hffb0;
   localparam int          KEY_BYTES      = 8;

   // axi responses
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // load phase, one bit, gray by nature
   typedef enum logic {
      FSP_LOAD = 1'b0,
      FSP_RUN  = 1'b1
   } fsp_phase_t;

endpackage : fsp_pkg

// ---- design/fsp_top.sv ----
// Overview of operation
// - each reset copies the nonvolatile option byte into the option shadow
// - option shadow reads zero in bits 5:2, always readable, writes ignored
// - backdoor key enable low forbids unlocking by key comparison
// - key compare writes accepted from firmware only, debug writes rejected
// - eight matching key bytes in ascending order unlock until next reset
// - option bit 6 high disables vector redirection, low keeps it
// - security code unsecured only for 1:0, every other code secure
// - while secure, unsecured sources are blocked from ram and program memory
// - key unlock or passing blank check forces effective code to 1:0
// - configuration bits 7:5 read and write, bits 4:0 read zero
// - key access low: key window writes start a memory command
// - key access high: key window writes are key comparison writes
// - each reset copies the nonvolatile protection byte into its shadow
// - protection shadow always readable, user program writes ignored
// - debug writes may modify the protection shadow
// - protect select bits 7:1 set the top unprotected boundary
// - program or erase inside the protected block is refused
// - protection disable high leaves no region protected
// - refused command sets violation flag, cleared by writing one
`timescale 1ns/1ps
`default_nettype none

module fsp_top #(
   parameter int ADDR_W = 16
) (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   reset_n,
   // axi4-lite write address and data
   input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output var  logic                   s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output var  logic                   s_axi_wready,
   // axi4-lite write response
   output var  logic [1:0]             s_axi_bresp,
   output var  logic                   s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0]      s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output var  logic                   s_axi_arready,
   output var  logic [31:0]            s_axi_rdata,
   output var  logic [1:0]             s_axi_rresp,
   output var  logic                   s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // register writes issued through the background debug port
   input  wire logic                   bus_from_debug,
   // nonvolatile contents of program memory
   input  wire logic [7:0]             nonvolatile_option_byte,
   input  wire logic [7:0]             nonvolatile_protection_byte,
   input  wire logic [63:0]            nonvolatile_backdoor_key,
   // cpu writes toward program memory space
   input  wire logic                   cpu_wr_valid,
   input  wire logic [15:0]            cpu_wr_addr,
   input  wire logic [7:0]             cpu_wr_data,
   input  wire logic                   cpu_wr_from_debug,
   // memory command controller
   input  wire logic                   prog_req,
   input  wire logic [15:0]            prog_addr,
   input  wire logic                   blank_check_pass,
   output var  logic                   prog_grant,
   output var  logic                   cmd_launch,
   output var  logic [15:0]            cmd_launch_addr,
   output var  logic [7:0]             cmd_launch_data,
   // security state toward cpu, debug and vector logic
   output var  logic [1:0]             security_state_code,
   output var  logic                   unsecured_access_block,
   output var  logic                   vector_redirect_disable,
   output var  logic                   security_unlocked
);
   import fsp_pkg::*;

   typedef struct packed {
      fsp_phase_t  phase;
      logic [7:0]  opt;
      logic [7:0]  prot;
      logic [2:0]  cfg;
      logic        viol;
      logic        unlocked;
      logic [2:0]  key_idx;
      logic        key_ok;
      logic        aw_got;
      logic [15:0] aw_addr;
      logic        w_got;
      logic [7:0]  w_data;
      logic        w_strb0;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        cmd_launch;
      logic [15:0] cmd_addr;
      logic [7:0]  cmd_data;
      logic        prog_grant;
      logic [1:0]  sec_eff;
      logic        block;
      logic        redirect_dis;
   } fsp_state_t;

   fsp_state_t r_reg;
   fsp_state_t r_next;

   // decoded conditions shared by the update logic and the checks
   logic        wr_fire;
   logic        run;
   logic        key_win;
   logic        key_wr;
   logic        key_byte_ok;
   logic        prog_protected;
   logic [15:0] boundary;

   assign run         = (r_reg.phase == FSP_RUN);
   assign wr_fire     = r_reg.aw_got && r_reg.w_got && !r_reg.bvalid;
   assign key_win     = run && cpu_wr_valid && (cpu_wr_addr[15:3] == KEY_BASE[15:3]);
   // firmware key write: key access set, key enable set, not from debug
   assign key_wr      = key_win && r_reg.cfg[CFG_KEY_WRITE_ACCESS_BIT-5] && r_reg.opt[OPT_BACKDOOR_KEY_ENABLE_BIT]
                        && !cpu_wr_from_debug;
   assign key_byte_ok = (cpu_wr_addr[2:0] == r_reg.key_idx)
                        && (cpu_wr_data == nonvolatile_backdoor_key[8*r_reg.key_idx +: 8]);
   // top of the unprotected region, filled out to a page
   assign boundary       = {r_reg.prot[7:1], BOUNDARY_FILL};
   assign prog_protected = !r_reg.prot[PROT_DIS_BIT] && (prog_addr > boundary);

   // whole next-state computation
   always_comb begin
      r_next            = r_reg;
      r_next.cmd_launch = 1'b0;
      r_next.prog_grant = 1'b0;

      // shadows take the nonvolatile bytes in the first cycle after reset
      if (r_reg.phase == FSP_LOAD) begin
         r_next.opt   = nonvolatile_option_byte;
         r_next.prot  = nonvolatile_protection_byte;
         r_next.phase = FSP_RUN;
      end

      // write address and data are taken in either order
      if (s_axi_awvalid && r_reg.awready) begin
         r_next.aw_got  = 1'b1;
         r_next.aw_addr = 16'(s_axi_awaddr);
      end
      if (s_axi_wvalid && r_reg.wready) begin
         r_next.w_got   = 1'b1;
         r_next.w_data  = s_axi_wdata[7:0];
         r_next.w_strb0 = s_axi_wstrb[0];
      end

      // register write once both halves are here
      if (wr_fire) begin
         r_next.aw_got = 1'b0;
         r_next.w_got  = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp  = RESP_OKAY;
         unique case (r_reg.aw_addr)
            ADDR_OPTION: begin
               // option shadow ignores writes, reprogram and reset instead
               r_next.opt = r_reg.opt;
            end
            ADDR_CONFIG: begin
               if (r_reg.w_strb0) begin
                  r_next.cfg = r_reg.w_data[7:5];
               end
            end
            ADDR_PROTECT: begin
               // only the debug port may rewrite the protection shadow
               if (r_reg.w_strb0 && bus_from_debug) begin
                  r_next.prot = r_reg.w_data;
               end
            end
            ADDR_STATUS: begin
               if (r_reg.w_strb0 && r_reg.w_data[STAT_VIOL_BIT]) begin
                  r_next.viol = 1'b0;
               end
            end
            default: begin
               r_next.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (r_reg.bvalid && s_axi_bready) begin
         r_next.bvalid = 1'b0;
      end

      // register read, data latched at the address handshake
      if (s_axi_arvalid && r_reg.arready) begin
         r_next.rvalid = 1'b1;
         r_next.rresp  = RESP_OKAY;
         unique case (16'(s_axi_araddr))
            ADDR_OPTION: begin
               r_next.rdata = {24'h00_0000, r_reg.opt[7:6], 4'h0, r_reg.sec_eff};
            end
            ADDR_CONFIG: begin
               r_next.rdata = {24'h00_0000, r_reg.cfg, 5'h00};
            end
            ADDR_PROTECT: begin
               r_next.rdata = {24'h00_0000, r_reg.prot};
            end
            ADDR_STATUS: begin
               r_next.rdata = {24'h00_0000, 2'h0, r_reg.viol, 5'h00};
            end
            default: begin
               r_next.rdata = 32'h0000_0000;
               r_next.rresp = RESP_SLVERR;
            end
         endcase
      end else if (r_reg.rvalid && s_axi_rready) begin
         r_next.rvalid = 1'b0;
      end

      // key window writes: command launch or key comparison
      if (key_win && !r_reg.cfg[CFG_KEY_WRITE_ACCESS_BIT-5]) begin
         r_next.cmd_launch = 1'b1;
         r_next.cmd_addr   = cpu_wr_addr;
         r_next.cmd_data   = cpu_wr_data;
      end else if (key_wr) begin
         // a byte out of order restarts the sequence at the next write
         if (cpu_wr_addr[2:0] != r_reg.key_idx) begin
            r_next.key_idx = 3'h0;
            r_next.key_ok  = 1'b1;
         end else if (r_reg.key_idx == 3'(KEY_BYTES - 1)) begin
            r_next.key_idx = 3'h0;
            r_next.key_ok  = 1'b1;
            if (r_reg.key_ok && key_byte_ok) begin
               r_next.unlocked = 1'b1;
            end
         end else begin
            r_next.key_idx = r_reg.key_idx + 3'h1;
            r_next.key_ok  = r_reg.key_ok && key_byte_ok;
         end
      end

      // passing blank check unlocks the part as well
      if (run && blank_check_pass) begin
         r_next.unlocked = 1'b1;
      end

      // program and erase screening; the set wins over a same-cycle clear
      if (run && prog_req) begin
         if (prog_protected) begin
            r_next.viol = 1'b1;
         end else begin
            r_next.prog_grant = 1'b1;
         end
      end

      // handshake readies and security outputs follow the new state
      r_next.awready      = (r_next.phase == FSP_RUN) && !r_next.aw_got && !r_next.bvalid;
      r_next.wready       = (r_next.phase == FSP_RUN) && !r_next.w_got && !r_next.bvalid;
      r_next.arready      = (r_next.phase == FSP_RUN) && !r_next.rvalid;
      r_next.sec_eff      = r_next.unlocked ? SEC_UNSECURED : r_next.opt[1:0];
      r_next.block        = (r_next.sec_eff != SEC_UNSECURED);
      r_next.redirect_dis = r_next.opt[OPT_NORED_BIT];
   end

   // state register; shadows hold a safe secure value until loaded
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         r_reg          <= '0;
         r_reg.phase    <= FSP_LOAD;
         r_reg.opt      <= NV_RESET;
         r_reg.prot     <= NV_RESET;
         r_reg.cfg      <= CFG_RESET;
         r_reg.key_ok   <= 1'b1;
         r_reg.sec_eff  <= SEC_RESET;
         r_reg.block    <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // outputs straight from the state register
   assign s_axi_awready           = r_reg.awready;
   assign s_axi_wready            = r_reg.wready;
   assign s_axi_bvalid            = r_reg.bvalid;
   assign s_axi_bresp             = r_reg.bresp;
   assign s_axi_arready           = r_reg.arready;
   assign s_axi_rvalid            = r_reg.rvalid;
   assign s_axi_rdata             = r_reg.rdata;
   assign s_axi_rresp             = r_reg.rresp;
   assign prog_grant              = r_reg.prog_grant;
   assign cmd_launch              = r_reg.cmd_launch;
   assign cmd_launch_addr         = r_reg.cmd_addr;
   assign cmd_launch_data         = r_reg.cmd_data;
   assign security_state_code     = r_reg.sec_eff;
   assign unsecured_access_block  = r_reg.block;
   assign vector_redirect_disable = r_reg.redirect_dis;
   assign security_unlocked       = r_reg.unlocked;

   // checks, all in the one clock domain
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence s_last_key_match;
      key_wr && r_reg.key_idx == 3'h7 && r_reg.key_ok && key_byte_ok;
   endsequence

   sequence s_write_to(logic [15:0] a);
      wr_fire && r_reg.aw_addr == a && r_reg.w_strb0;
   endsequence

   // sampled reset_n keeps the release edge, where the state is still in reset, from starting a load check
   a_option_load: assert property (
      reset_n && r_reg.phase == FSP_LOAD |=> r_reg.opt == $past(nonvolatile_option_byte))
      else $error("option shadow not loaded from nonvolatile byte");

   a_protect_load: assert property (
      reset_n && r_reg.phase == FSP_LOAD |=> r_reg.prot == $past(nonvolatile_protection_byte) ##1 run)
      else $error("protection shadow not loaded");

   a_option_ro: assert property (
      s_write_to(ADDR_OPTION) |=> $stable(r_reg.opt) && r_reg.bvalid)
      else $error("option shadow changed by a write");

   a_protect_user: assert property (
      s_write_to(ADDR_PROTECT) and !bus_from_debug |=> $stable(r_reg.prot))
      else $error("user write changed protection shadow");

   a_protect_debug: assert property (
      s_write_to(ADDR_PROTECT) and bus_from_debug |=> r_reg.prot == $past(r_reg.w_data))
      else $error("debug write did not reach protection shadow");

   a_config_rw: assert property (
      s_write_to(ADDR_CONFIG) |=> r_reg.cfg == $past(r_reg.w_data[7:5]))
      else $error("configuration bits 7:5 not written");

   a_key_disabled: assert property (
      run && !r_reg.opt[OPT_BACKDOOR_KEY_ENABLE_BIT] && !blank_check_pass && !r_reg.unlocked
      |=> !r_reg.unlocked)
      else $error("unlocked with backdoor key disabled");

   a_key_debug_rej: assert property (
      key_win && cpu_wr_from_debug && !blank_check_pass |=> $stable(r_reg.key_idx) && $stable(r_reg.unlocked))
      else $error("debug key write was taken");

   a_key_unlock: assert property (
      s_last_key_match |=> security_unlocked && security_state_code == SEC_UNSECURED)
      else $error("matching key did not unlock");

   a_unlock_held: assert property (
      r_reg.unlocked |=> r_reg.unlocked[*8])
      else $error("unlock lost before reset");

   a_sec_decode: assert property (
      run && !r_reg.unlocked |-> unsecured_access_block == (r_reg.opt[1:0] != 2'h2))
      else $error("security code decoded wrongly");

   a_blank_unlock: assert property (
      run && blank_check_pass |=> !unsecured_access_block && security_state_code == 2'h2)
      else $error("blank check did not unlock");

   a_redirect_bit: assert property (
      reset_n && r_reg.phase == FSP_LOAD |=> vector_redirect_disable == $past(nonvolatile_option_byte[6]))
      else $error("redirect disable does not follow option bit 6");

   a_cmd_launch: assert property (
      key_win && !r_reg.cfg[0] |=> cmd_launch && cmd_launch_addr == $past(cpu_wr_addr))
      else $error("key window write did not launch command");

   a_key_no_cmd: assert property (
      key_win && r_reg.cfg[0] |=> !cmd_launch)
      else $error("key compare write launched a command");

   a_prot_refuse: assert property (
      run && prog_req && prog_protected |=> !prog_grant && r_reg.viol)
      else $error("protected location not refused");

   a_prot_off: assert property (
      run && prog_req && r_reg.prot[0] |=> prog_grant)
      else $error("operation refused with protection disabled");

   a_viol_clear: assert property (
      s_write_to(ADDR_STATUS) and r_reg.w_data[5] and !(prog_req && prog_protected)
      |=> !r_reg.viol)
      else $error("violation flag not cleared by writing one");

endmodule : fsp_top

`default_nettype wire

// ---- tb/fsp_partner.sv ----
`timescale 1ns/1ps
`default_nettype none

// far side: nonvolatile bytes and the memory command controller
module fsp_partner #(
   parameter logic [63:0] KEY = 64'h0000_0000_0000_0000
) (
   // clock
   input  wire logic        sys_clk,
   // nonvolatile contents
   output var  logic [7:0]  nv_opt,
   output var  logic [7:0]  nv_prot,
   output var  logic [63:0] nv_key,
   // command controller
   output var  logic        prog_req,
   output var  logic [15:0] prog_addr,
   output var  logic        blank_ok,
   input  wire logic        prog_grant
);
   logic granted;

   // idle controller at time zero
   initial begin
      nv_key = KEY;
      prog_req = 1'b0;
      prog_addr = 16'h0000;
      blank_ok = 1'b0;
   end

   // new bytes only reach the shadows at the next reset
   task automatic reprogram(input logic [7:0] o, input logic [7:0] p);
      nv_opt = o;
      nv_prot = p;
   endtask : reprogram

   // one program or erase request, grant sampled after the taking edge
   task automatic request(input logic [15:0] a);
      @(posedge sys_clk);
      prog_req <= 1'b1;
      prog_addr <= a;
      @(posedge sys_clk);
      prog_req <= 1'b0;
      prog_addr <= ~a; // released address never shows the stale value
      #1 granted = prog_grant;
   endtask : request

   // array found erased after protection was cleared by debug
   task automatic blank_check();
      @(posedge sys_clk);
      blank_ok <= 1'b1;
      @(posedge sys_clk);
      blank_ok <= 1'b0;
      #1;
   endtask : blank_check
endmodule : fsp_partner
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import fsp_pkg::*;
   localparam logic [63:0] KEY = 64'h8877_6655_4433_2211;
   logic        sys_clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, from_dbg, cpu_valid, cpu_dbg, prog_req;
   logic        blank_ok, grant, launch, block, nored, unlocked, launched, hit;
   logic [15:0] awaddr, araddr, cpu_addr, prog_addr, launch_addr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, code, resp;
   logic [7:0]  nv_opt, nv_prot, cpu_data, launch_data;
   logic [63:0] nv_key;
   int          error_cnt, checks_done, cycles;

   fsp_top i_fsp_top (.sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus_from_debug(from_dbg),
      .nonvolatile_option_byte(nv_opt), .nonvolatile_protection_byte(nv_prot),
      .nonvolatile_backdoor_key(nv_key), .cpu_wr_valid(cpu_valid), .cpu_wr_addr(cpu_addr),
      .cpu_wr_data(cpu_data), .cpu_wr_from_debug(cpu_dbg), .prog_req(prog_req), .prog_addr(prog_addr),
      .blank_check_pass(blank_ok), .prog_grant(grant), .cmd_launch(launch), .cmd_launch_addr(launch_addr),
      .cmd_launch_data(launch_data), .security_state_code(code), .unsecured_access_block(block),
      .vector_redirect_disable(nored), .security_unlocked(unlocked));

   fsp_partner #(.KEY(KEY)) i_fsp_partner (.sys_clk(sys_clk), .nv_opt(nv_opt), .nv_prot(nv_prot),
      .nv_key(nv_key), .prog_req(prog_req), .prog_addr(prog_addr), .blank_ok(blank_ok), .prog_grant(grant));

   // 125 MHz clock
   initial sys_clk = 1'b0;
   always #4 sys_clk = ~sys_clk;

   // a hang is cut short well beyond the expected run length
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         conclude();
      end
   end

   task automatic conclude();
      if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask : chk

   // reset held 16 cycles, then the load edge passes before any request
   task automatic do_reset();
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
   endtask : do_reset

   // address and data offered together, each released when taken
   task automatic wr(input logic [15:0] a, input logic [7:0] v, input logic dbg);
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= {24'h00_0000, v};
      wstrb <= 4'h1;
      from_dbg <= dbg;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] a);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : rd

   // one cpu write pulse; launch is looked at in the cycle after it is taken
   task automatic cpu_wr(input logic [15:0] a, input logic [7:0] v, input logic dbg);
      @(posedge sys_clk);
      cpu_valid <= 1'b1;
      cpu_addr <= a;
      cpu_data <= v;
      cpu_dbg <= dbg;
      @(posedge sys_clk);
      cpu_valid <= 1'b0;
      #1 launched = launch;
   endtask : cpu_wr

   // eight key bytes in ascending order
   task automatic key_seq(input logic dbg);
      hit = 1'b0;
      for (int i = 0; i < KEY_BYTES; i++) begin
         cpu_wr(KEY_BASE + 16'(i), KEY[8*i +: 8], dbg);
         hit = hit | launched;
      end
   endtask : key_seq

   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
      {from_dbg, cpu_valid, cpu_addr, cpu_data, cpu_dbg} = '0;
      reset_n = 1'b0;
      i_fsp_partner.reprogram(8'hbf, 8'ha0);
      do_reset();
      rd(ADDR_OPTION);
      chk("option", 32'h0000_0083, d);
      chk("block", 1'b1, block);
      chk("redirect", 1'b0, nored);
      rd(ADDR_PROTECT);
      chk("protect", 32'h0000_00a0, d);
      rd(ADDR_CONFIG);
      chk("config", 32'h0000_0000, d);
      wr(ADDR_OPTION, 8'h00, 1'b0);
      rd(ADDR_OPTION);
      chk("option kept", 32'h0000_0083, d);
      wr(ADDR_PROTECT, 8'h01, 1'b0);
      rd(ADDR_PROTECT);
      chk("protect kept", 32'h0000_00a0, d);
      wr(16'h6080, 8'h00, 1'b0);
      chk("unmapped write", RESP_SLVERR, resp);
      rd(16'h6080);
      chk("unmapped read", RESP_SLVERR, resp);
      i_fsp_partner.request(16'ha200);
      chk("grant protected", 1'b0, i_fsp_partner.granted);
      rd(ADDR_STATUS);
      chk("violation", 1'b1, d[STAT_VIOL_BIT]);
      wr(ADDR_STATUS, 8'h20, 1'b0);
      rd(ADDR_STATUS);
      chk("violation clear", 1'b0, d[STAT_VIOL_BIT]);
      i_fsp_partner.request(16'ha1ff);
      chk("grant boundary", 1'b1, i_fsp_partner.granted);
      cpu_wr(16'hffb3, 8'h5a, 1'b0);
      chk("launch", 1'b1, launched);
      chk("launch addr", 16'hffb3, launch_addr);
      chk("launch data", 8'h5a, launch_data);
      wr(ADDR_CONFIG, 8'hff, 1'b0);
      rd(ADDR_CONFIG);
      chk("config rw", 32'h0000_00e0, d);
      key_seq(1'b1);
      chk("debug key", 1'b0, unlocked);
      key_seq(1'b0);
      chk("key launch", 1'b0, hit);
      chk("key unlock", 1'b1, unlocked);
      chk("key code", SEC_UNSECURED, code);
      chk("key block", 1'b0, block);
      wr(ADDR_PROTECT, 8'h01, 1'b1);
      rd(ADDR_PROTECT);
      chk("debug protect", 32'h0000_0001, d);
      i_fsp_partner.request(16'hffff);
      chk("grant open", 1'b1, i_fsp_partner.granted);
      i_fsp_partner.reprogram(8'h41, 8'ha0);
      do_reset();
      chk("redirect off", 1'b1, nored);
      chk("code", 2'b01, code);
      wr(ADDR_CONFIG, 8'h20, 1'b0);
      key_seq(1'b0);
      chk("key disabled", 1'b0, unlocked);
      wr(ADDR_PROTECT, 8'h01, 1'b1);
      i_fsp_partner.blank_check();
      chk("blank unlock", 1'b1, unlocked);
      chk("blank code", SEC_UNSECURED, code);
      conclude();
   end
endmodule : tb_top
`default_nettype wire
